// ---- ipbc.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ipbc_defines.vh"

module ipbc #(
	parameter FRAMER_ID = 0
) (
	input  wire       clock,          // System clock, 100 MHz.
	input  wire       srst,           // Synchronous reset, active high.
	input  wire [7:0] reg_addr,       // Register address.
	input  wire       reg_wr,         // Write strobe, one cycle.
	input  wire       reg_rd,         // Read strobe, one cycle.
	input  wire [7:0] reg_wdata,      // Write data.
	output reg  [7:0] reg_rdata,      // Read data, valid the cycle after reg_rd.
	input  wire       bus_four_way,   // Pin: bus holds four framers (used by slaves).
	input  wire       bus_clock_in,   // Pin: shared bus clock.
	output reg        bus_clock_out,  // Shared bus clock drive.
	output reg        bus_clock_oe,   // Shared bus clock enable, high when driven.
	input  wire       bus_sync_in,    // Pin: shared bus frame sync.
	output reg        bus_sync_out,   // Shared bus frame sync drive.
	output reg        bus_sync_oe,    // Shared bus frame sync enable.
	output reg        bus_data_out,   // Shared data bus drive.
	output reg        bus_data_oe,    // Shared data bus enable.
	output reg        bus_sig_out,    // Shared signaling bus drive.
	output reg        bus_sig_oe,     // Shared signaling bus enable.
	output reg  [4:0] es_channel,     // Elastic store channel for the next byte.
	output reg        es_read,        // Elastic store read pulse, one cycle.
	input  wire [7:0] es_data,        // Elastic store data byte for es_channel.
	input  wire [7:0] es_signaling    // Elastic store signaling byte for es_channel.
);

	// ======================================================================
	// Constants
	localparam [63:0] STEP_TWO_W  = ((64'd2 * `IPBC_RATE_TWO_KHZ) << `IPBC_ACC_BITS)
		/ `IPBC_CLOCK_KHZ;
	localparam [63:0] STEP_FOUR_W = ((64'd2 * `IPBC_RATE_FOUR_KHZ) << `IPBC_ACC_BITS)
		/ `IPBC_CLOCK_KHZ;
	localparam [`IPBC_ACC_BITS-1:0] STEP_TWO  = STEP_TWO_W[`IPBC_ACC_BITS-1:0];
	localparam [`IPBC_ACC_BITS-1:0] STEP_FOUR = STEP_FOUR_W[`IPBC_ACC_BITS-1:0];
	localparam [1:0] MY_ID = FRAMER_ID[1:0];

	// ======================================================================
	// Control register
	reg  [7:0] control;
	wire       enable    = control[`IPBC_BIT_ENABLE];
	wire       frame_ilv = control[`IPBC_BIT_TYPE];
	wire [1:0] msel      = {control[`IPBC_BIT_MASTER_SELECT_BIT1], control[`IPBC_BIT_MASTER_SELECT_BIT0]};
	wire       is_master = enable && (msel == `IPBC_MSEL_MASTER_TWO ||
		msel == `IPBC_MSEL_MASTER_FOUR);
	wire       is_slave  = enable && (msel == `IPBC_MSEL_SLAVE);
	wire       active    = is_master || is_slave;

	always @(posedge clock) begin
		if (srst) begin
			control <= `IPBC_CONTROL_RESET;
			reg_rdata <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == `IPBC_REG_CONTROL) begin
				control <= reg_wdata;
			end
			if (reg_rd && reg_addr == `IPBC_REG_CONTROL) begin
				reg_rdata <= control;
			end else if (reg_rd) begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ======================================================================
	// Pin synchronisers: three flops, a level counts once stages two and three agree.
	reg  [2:0] clk_sync;
	reg  [2:0] syn_sync;
	reg  [2:0] way_sync;
	reg        clk_level;
	reg        syn_level;
	reg        way_level;

	always @(posedge clock) begin
		if (srst) begin
			clk_sync <= 3'h0;
			syn_sync <= 3'h0;
			way_sync <= 3'h0;
			clk_level <= 1'b0;
			syn_level <= 1'b0;
			way_level <= 1'b0;
		end else begin
			clk_sync <= {clk_sync[1:0], bus_clock_in};
			syn_sync <= {syn_sync[1:0], bus_sync_in};
			way_sync <= {way_sync[1:0], bus_four_way};
			if (clk_sync[1] == clk_sync[2]) begin
				clk_level <= clk_sync[2];
			end
			if (syn_sync[1] == syn_sync[2]) begin
				syn_level <= syn_sync[2];
			end
			if (way_sync[1] == way_sync[2]) begin
				way_level <= way_sync[2];
			end
		end
	end

	wire slave_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_level;

	// ======================================================================
	// Bus size and this framer's position on the bus
	wire       four_way = is_master ? (msel == `IPBC_MSEL_MASTER_FOUR) : way_level;
	wire [1:0] position = four_way ? MY_ID : {1'b0, MY_ID[0]};
	wire [6:0] last_byte = four_way ? 7'd127 : 7'd63;

	// ======================================================================
	// Master bus clock: phase accumulator at twice the bit rate.
	reg  [`IPBC_ACC_BITS-1:0] phase;
	wire [`IPBC_ACC_BITS:0]   phase_sum = {1'b0, phase} + {1'b0, (four_way ? STEP_FOUR : STEP_TWO)};
	reg                       half_clk;
	wire                      master_rise = is_master && phase_sum[`IPBC_ACC_BITS] && !half_clk;

	always @(posedge clock) begin
		if (srst || !is_master) begin
			phase <= {`IPBC_ACC_BITS{1'b0}};
			half_clk <= 1'b0;
		end else begin
			phase <= phase_sum[`IPBC_ACC_BITS-1:0];
			if (phase_sum[`IPBC_ACC_BITS]) begin
				half_clk <= !half_clk;
			end
		end
	end

	// ======================================================================
	// Slot timing
	reg  [2:0] bit_cnt;
	reg  [6:0] byte_cnt;
	reg  [7:0] data_shift;
	reg  [7:0] sig_shift;
	reg        own_slot;

	wire tick = is_master ? master_rise : (is_slave && slave_rise);
	wire wrap = is_master ? (bit_cnt == 3'd7 && byte_cnt == last_byte)
		: syn_level;
	wire [6:0] next_byte = wrap ? 7'd0 : byte_cnt + 7'd1;
	wire [6:0] ahead_byte = (next_byte == last_byte) ? 7'd0 : next_byte + 7'd1;

	// Byte interleave rotates owners every byte; frame interleave every 32 bytes.
	function [6:0] slot_map;
		input [6:0] b;
		input       frm;
		input       four;
		begin
			if (frm) begin
				slot_map = {b[4:0], b[6:5]};
			end else if (four) begin
				slot_map = {b[6:2], b[1:0]};
			end else begin
				slot_map = {b[5:1], 1'b0, b[0]};
			end
		end
	endfunction

	wire [6:0] next_map  = slot_map(next_byte, frame_ilv, four_way);
	wire [6:0] ahead_map = slot_map(ahead_byte, frame_ilv, four_way);
	wire       next_own  = (next_map[1:0] == position);

	always @(posedge clock) begin
		if (srst || !active) begin
			bit_cnt <= 3'd0;
			byte_cnt <= 7'd0;
			data_shift <= 8'h00;
			sig_shift <= 8'h00;
			own_slot <= 1'b0;
			es_channel <= 5'd0;
			es_read <= 1'b0;
		end else begin
			es_read <= 1'b0;
			if (tick) begin
				if (bit_cnt == 3'd7 || (is_slave && wrap)) begin
					bit_cnt <= 3'd0;
					byte_cnt <= next_byte;
					own_slot <= next_own;
					data_shift <= es_data;
					sig_shift <= es_signaling;
					es_read <= next_own;
					es_channel <= ahead_map[6:2];
				end else begin
					bit_cnt <= bit_cnt + 3'd1;
					data_shift <= {data_shift[6:0], 1'b0};
					sig_shift <= {sig_shift[6:0], 1'b0};
				end
			end
		end
	end

	// ======================================================================
	// Pin drivers
	always @(posedge clock) begin
		if (srst) begin
			bus_clock_out <= 1'b0;
			bus_clock_oe <= 1'b0;
			bus_sync_out <= 1'b0;
			bus_sync_oe <= 1'b0;
			bus_data_out <= 1'b0;
			bus_data_oe <= 1'b0;
			bus_sig_out <= 1'b0;
			bus_sig_oe <= 1'b0;
		end else begin
			bus_clock_out <= half_clk;
			bus_clock_oe <= is_master;
			bus_sync_oe <= is_master;
			if (tick && is_master) begin
				bus_sync_out <= wrap;
			end else if (!is_master) begin
				bus_sync_out <= 1'b0;
			end
			bus_data_out <= data_shift[7];
			bus_sig_out <= sig_shift[7];
			bus_data_oe <= active && own_slot;
			bus_sig_oe <= active && own_slot;
		end
	end

endmodule

`default_nettype wire

// ---- ipbc_defines.vh ----
// Contract
// - With interleaving on, this framer's data and signaling streams reach the shared bus through the elastic store.
// - A 4.096 MHz shared bus carries exactly two framers.
// - An 8.192 MHz shared bus carries all four framers.
// - The interleave type bit picks byte units when zero and whole-frame units when one.
// - Byte interleave works even when the framers' received lines are mutually asynchronous.
// - Bit 3 of the control register turns interleaved operation on when one and off when zero.
// - Master select decodes 00 slave, 01 master at 4.096 MHz, 10 master at 8.192 MHz, 11 reserved.
`ifndef IPBC_DEFINES_VH
`define IPBC_DEFINES_VH

// ==========================================================================
// Register map
`define IPBC_REG_CONTROL      8'hb5
`define IPBC_CONTROL_RESET    8'h00
`define IPBC_BIT_ENABLE       3
`define IPBC_BIT_TYPE         2
`define IPBC_BIT_MASTER_SELECT_BIT0        1
`define IPBC_BIT_MASTER_SELECT_BIT1        0

// ==========================================================================
// Master select codes, written as {master_select_bit1, master_select_bit0}
`define IPBC_MSEL_SLAVE       2'b00
`define IPBC_MSEL_MASTER_TWO  2'b01
`define IPBC_MSEL_MASTER_FOUR 2'b10
`define IPBC_MSEL_RESERVED    2'b11

// ==========================================================================
// Timing
`define IPBC_CLOCK_KHZ        100000
`define IPBC_RATE_TWO_KHZ     4096
`define IPBC_RATE_FOUR_KHZ    8192
`define IPBC_ACC_BITS         24
`define IPBC_BYTES_PER_FRAME  32

`endif

// ---- ipbc_unused_note_placeholder.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- ipbc_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====
// Port checks
module ipbc_chk (
	input wire logic       clock,        // Clock.
	input wire logic       srst,         // Reset.
	input wire logic [7:0] reg_addr,     // Address.
	input wire logic       reg_wr,       // Write.
	input wire logic       reg_rd,       // Read.
	input wire logic [7:0] reg_wdata,    // Write data.
	input wire logic [7:0] reg_rdata,    // Read data.
	input wire logic       bus_clock_oe, // Clock enable.
	input wire logic       bus_sync_oe,  // Sync enable.
	input wire logic       bus_data_oe,  // Data enable.
	input wire logic       bus_sig_oe,   // Signaling enable.
	input wire logic       es_read       // Store read.
);
	logic [7:0] ctl;
	logic [1:0] idle;
	wire  [1:0] ms = {ctl[0], ctl[1]};
	wire        act = ctl[3] && ms != 2'b11;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	always_ff @(posedge clock) begin
		if (srst) begin
			ctl <= 8'h00;
			idle <= 2'h0;
		end else begin
			if (reg_wr && reg_addr == 8'hb5)
				ctl <= reg_wdata;
			idle <= act ? 2'h0 : (idle == 2'h3 ? idle : idle + 2'h1);
		end
	end
	a_inactive_silent: assert property (idle == 2'h3 |->
		!(bus_data_oe | bus_sig_oe | bus_clock_oe | bus_sync_oe | es_read))
		else $error("Output driven while inactive");
	a_slave_no_clock: assert property ((ms == 2'b00) [*3] |-> !bus_clock_oe && !bus_sync_oe)
		else $error("Slave drives bus clock");
	a_master_clock: assert property ((act && ms != 2'b00) [*3] |-> bus_clock_oe)
		else $error("Master leaves bus clock undriven");
	a_read_value: assert property (reg_rd && !reg_wr && reg_addr == 8'hb5 |=>
		reg_rdata == $past(ctl))
		else $error("Control read back wrong");
	a_unmapped_zero: assert property (reg_rd && reg_addr != 8'hb5 |=> reg_rdata == 8'h00)
		else $error("Unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("Read data moved without read");
	a_read_pulse: assert property (es_read |=> !es_read)
		else $error("Store read longer than one cycle");
	a_slot_pairs: assert property (bus_data_oe == bus_sig_oe)
		else $error("Data and signaling slots differ");
	a_sync_master: assert property (bus_sync_oe |-> bus_clock_oe)
		else $error("Sync driven by non master");
endmodule
bind ipbc ipbc_chk ipbc_chk_inst (.clock(clock), .srst(srst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.bus_clock_oe(bus_clock_oe), .bus_sync_oe(bus_sync_oe), .bus_data_oe(bus_data_oe),
	.bus_sig_oe(bus_sig_oe), .es_read(es_read));
`default_nettype wire

// ---- ipbc_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// =====
// Bus master and elastic store seen from a slave
module ipbc_far_end (
	input  wire logic       clock,       // System clock.
	input  wire logic       run,         // Run bus clock.
	input  wire logic [4:0] es_channel,  // Channel asked.
	output logic            bus_clock,   // Bus clock.
	output logic            bus_sync,    // Frame sync.
	output logic [7:0]      es_data,     // Data byte.
	output logic [7:0]      es_signaling // Signaling byte.
);
	logic [3:0] ph;
	logic [9:0] bit_cnt;
	assign es_data = {3'h5, es_channel};
	assign es_signaling = {3'h2, es_channel};
	// Phase is unrelated to the framer, and the clock stands still when idle.
	assign bus_clock = run && ph < 4'h6;
	assign bus_sync = run && bit_cnt == 10'h000;
	always_ff @(posedge clock) begin
		if (!run) begin
			ph <= 4'h0;
			bit_cnt <= 10'h000;
		end else begin
			ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
			if (ph == 4'hb)
				bit_cnt <= bit_cnt + 10'h001;
		end
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clock = 1'b0;
	logic       srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic       run = 1'b0;
	logic       four_way = 1'b1;
	wire  [7:0] reg_rdata, es_data, es_sig;
	wire  [4:0] es_ch;
	wire        fclk, fsync, ck_o, ck_oe, d_o, d_oe, s_o, s_oe, es_read;
	wire        sy_o, sy_oe;
	int         n_mismatch = 0;
	int         check_count = 0;
	always #5 clock = ~clock;
	ipbc #(.FRAMER_ID(1)) ipbc_inst (.clock(clock), .srst(srst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.bus_four_way(four_way), .bus_clock_in(fclk), .bus_clock_out(ck_o), .bus_clock_oe(ck_oe),
		.bus_sync_in(fsync), .bus_sync_out(sy_o), .bus_sync_oe(sy_oe), .bus_data_out(d_o),
		.bus_data_oe(d_oe), .bus_sig_out(s_o), .bus_sig_oe(s_oe), .es_channel(es_ch),
		.es_read(es_read), .es_data(es_data), .es_signaling(es_sig));
	ipbc_far_end ipbc_far_end_inst (.clock(clock), .run(run), .es_channel(es_ch),
		.bus_clock(fclk), .bus_sync(fsync), .es_data(es_data), .es_signaling(es_sig));
	task automatic chk(input string nm, input logic [7:0] exp, got);
		check_count++;
		if (exp !== got) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		chk("reg_rdata", exp, reg_rdata);
	endtask
	task automatic t_regs;
		rd(8'hb5, 8'h00);
		wr(8'hb5, 8'h06);
		rd(8'hb5, 8'h06);
		wr(8'hb4, 8'h3c);
		rd(8'hb5, 8'h06);
		rd(8'hb6, 8'h00);
	endtask
	task automatic t_rate(input logic [7:0] code, input int exp);
		int n;
		logic p;
		n = 0;
		p = 1'b0;
		wr(8'hb5, code);
		repeat (100) @(posedge clock);
		repeat (2000) begin
			@(negedge clock);
			if (ck_o === 1'b1 && !p)
				n++;
			p = ck_o;
		end
		chk("bus_clock_oe", (exp > 0) ? 8'h01 : 8'h00, {7'h00, ck_oe});
		check_count++;
		if (n < exp - 2 || n > exp + 2) begin
			n_mismatch++;
			$display("Error clock_rises expected %0d seen %0d", exp, n);
		end
	endtask
	task automatic t_slave(input logic [7:0] code, first);
		logic [7:0] d, s;
		logic [9:0] b;
		int k, w;
		k = 0;
		wr(8'hb5, code);
		run <= 1'b1;
		for (w = 0; w < 6000 && k < 8; w++) begin
			@(negedge clock);
			if (ipbc_far_end_inst.ph == 4'h9 && d_oe === 1'b1) begin
				if (k == 0)
					b = ipbc_far_end_inst.bit_cnt;
				d = {d[6:0], d_o};
				s = {s[6:0], s_o};
				k++;
			end
		end
		run <= 1'b0;
		if (k < 8) begin
			n_mismatch++;
			$display("Error slave_slot expected 8 seen %0d", k);
			tally_and_finish;
		end
		chk("first_byte", first, {1'b0, b[9:3]});
		chk("bus_data", 8'ha0, d);
		chk("bus_sig", 8'h40, s);
		wr(8'hb5, 8'h00);
		repeat (20) @(posedge clock);
	endtask
	// A four-way bus frame is 1024 bits at 8.192 MHz, which is 12500 system clocks.
	task automatic t_sync;
		int w, r0, r1;
		logic p;
		r0 = -1;
		r1 = -1;
		p = 1'b1;
		wr(8'hb5, 8'h09);
		for (w = 0; w < 30000 && r1 < 0; w++) begin
			@(negedge clock);
			if (sy_o === 1'b1 && !p) begin
				if (r0 < 0)
					r0 = w;
				else
					r1 = w;
			end
			p = sy_o;
		end
		chk("bus_sync_oe", 8'h01, {7'h00, sy_oe});
		check_count++;
		if (r1 - r0 < 12498 || r1 - r0 > 12502) begin
			n_mismatch++;
			$display("Error sync_period expected 12500 seen %0d", r1 - r0);
		end
		wr(8'hb5, 8'h00);
		repeat (20) @(posedge clock);
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		srst <= 1'b0;
		t_regs;
		t_rate(8'h0a, 82);
		t_rate(8'h0e, 82);
		t_rate(8'h09, 164);
		t_rate(8'h0d, 164);
		t_rate(8'h08, 0);
		t_rate(8'h02, 0);
		t_slave(8'h08, 8'h01);
		t_slave(8'h0c, 8'h20);
		four_way <= 1'b0;
		t_slave(8'h08, 8'h01);
		t_sync;
		tally_and_finish;
	end
endmodule
`default_nettype wire
